/* File: iexec_pkg.sv */
/*
 * Shared constants and types for the rotate / set / sleep instruction unit.
 * Assumes a 32-bit AXI4-Lite register bus and an 8-bit data memory word.
 */
package iexec_pkg;

   // ==========================================================================
   // Register offsets (byte addresses)
   // ==========================================================================
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] INSTR_OFS = 8'h04;
   localparam logic [7:0] W_OFS = 8'h08;
   localparam logic [7:0] BANK_OFS = 8'h0C;
   localparam logic [7:0] STAT_OFS = 8'h10;
   localparam logic [7:0] INDEX_OFS = 8'h14;
   localparam logic [7:0] MADDR_OFS = 8'h18;
   localparam logic [7:0] MDATA_OFS = 8'h1C;

   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int CTRL_GO_BIT = 0;
   localparam int CTRL_EXT_BIT = 1;
   localparam int ST_C_BIT = 0;
   localparam int ST_Z_BIT = 1;
   localparam int ST_N_BIT = 2;
   localparam int ST_PWR_DOWN_BIT = 3;
   localparam int ST_TIMEOUT_BIT = 4;
   localparam int ST_SLEEP_BIT = 5;
   localparam int ST_BUSY_BIT = 6;

   // ==========================================================================
   // Opcodes and values
   // ==========================================================================
   localparam logic [5:0] ROT_OPC = 6'h10;
   localparam logic [6:0] SET_OPC = 7'h34;
   localparam logic [15:0] SLEEP_OPC = 16'h0003;
   localparam logic [7:0] LIT_OFS_LIMIT = 8'h5F;
   localparam logic [7:0] ALL_ONES = 8'hFF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam logic [15:0] INSTR_RST = 16'h0000;
   localparam logic [7:0] W_RST = 8'h00;

   // ==========================================================================
   // Types
   // ==========================================================================
   typedef enum logic [2:0] {
      PH_IDLE = 3'h0,
      PH_Q1 = 3'h1,
      PH_Q2 = 3'h2,
      PH_Q3 = 3'h3,
      PH_Q4 = 3'h4,
      PH_SLEEP = 3'h5
   } phase_t;

   typedef struct packed {
      logic timeout_flag_n;
      logic power_down_flag_n;
      logic n;
      logic z;
      logic c;
   } status_t;

   localparam status_t STATUS_RST = '{timeout_flag_n: 1'h1, power_down_flag_n: 1'h1,
                                      n: 1'h0, z: 1'h0, c: 1'h0};

   typedef struct packed {
      logic rot;
      logic set;
      logic slp;
      logic dst;
      logic acc;
      logic [7:0] f;
   } dec_t;

endpackage

/* File: instr_data_ram.sv */
/*
 * Single-port data memory with registered read data.
 * Assumes one clock; read data show the addressed word one edge after the address.
 */
module instr_data_ram #(
   parameter int AW = 12,
   parameter int DW = 8
) (
   input wire logic clk,
   input wire logic ce,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata_q
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // ==========================================================================
   // Storage
   // ==========================================================================
   // Read returns the old word on a write cycle, which keeps the port simple.
   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         if (we)
         begin
            mem[addr] <= wdata;
         end
         rdata_q <= mem[addr];
      end
   end

endmodule

/* File: instr_exec.sv */
/*
 * Execution unit for rotate-right-no-carry, set-all-ones and sleep, with its
 * data memory, working register and status flags behind an AXI4-Lite slave.
 * Assumes one clock aclk, synchronous active-low aresetn and asynchronous
 * wake pins from the watchdog and other wake sources.
 */
// Implementation choices: the register offsets and the AXI4-Lite slave port.
module instr_exec #(
   parameter int BANK_W = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic watchdog_timeout,
   input wire logic wake_req,
   output logic core_asleep,
   output logic osc_stop,
   output logic watchdog_clear,
   output logic postscaler_clear
);

   localparam int ADDR_W = BANK_W + 8;

   logic [15:0] instr_q;
   logic [7:0] w_q;
   logic [BANK_W-1:0] bank_select_reg_q;
   logic [ADDR_W-1:0] index_q, maddr_q, ea_q, ea_d;
   logic ext_en_q, start_q, idle_prev_q;
   iexec_pkg::status_t st_q;
   iexec_pkg::phase_t ph_q;
   iexec_pkg::dec_t dec_q, dec_d;
   logic [7:0] result_q, mem_rdata, mem_wdata;
   logic [ADDR_W-1:0] mem_addr;
   logic mem_we, busy, do_write, do_read, wr_hit, rd_err;
   logic [1:0] pin_s1_q, pin_s2_q;
   logic watchdog_s2, wake_s2;
   logic aw_hold_q, w_hold_q, ar_hold_q;
   logic [7:0] awaddr_q, araddr_q;
   logic [31:0] wdata_q, rd_word;
   logic [3:0] wstrb_q;

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ==========================================================================
   // Pin synchronisers
   // ==========================================================================
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_s1_q <= 2'h0;
         pin_s2_q <= 2'h0;
      end
      else if (ce)
      begin
         pin_s1_q <= {watchdog_timeout, wake_req};
         pin_s2_q <= pin_s1_q;
      end
   end

   assign watchdog_s2 = pin_s2_q[1];
   assign wake_s2 = pin_s2_q[0];

   // ==========================================================================
   // Decode and operand address
   // ==========================================================================
   always_comb
   begin
      dec_d.rot = (instr_q[15:10] == iexec_pkg::ROT_OPC);
      dec_d.set = (instr_q[15:9] == iexec_pkg::SET_OPC);
      dec_d.slp = (instr_q == iexec_pkg::SLEEP_OPC);
      dec_d.dst = instr_q[9];
      dec_d.acc = instr_q[8];
      dec_d.f = instr_q[7:0];
      if (dec_d.acc)
      begin
         ea_d = {bank_select_reg_q, dec_d.f};
      end
      else if (ext_en_q && dec_d.f <= iexec_pkg::LIT_OFS_LIMIT)
      begin
         ea_d = index_q + ADDR_W'(dec_d.f);
      end
      else if (dec_d.f <= iexec_pkg::LIT_OFS_LIMIT)
      begin
         ea_d = {{BANK_W{1'b0}}, dec_d.f};
      end
      else
      begin
         ea_d = {{BANK_W{1'b1}}, dec_d.f};
      end
   end

   // ==========================================================================
   // Phase sequencer
   // ==========================================================================
   assign busy = (ph_q == iexec_pkg::PH_Q1) || (ph_q == iexec_pkg::PH_Q2) ||
                 (ph_q == iexec_pkg::PH_Q3) || (ph_q == iexec_pkg::PH_Q4);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ph_q <= iexec_pkg::PH_IDLE;
         dec_q <= '0;
         ea_q <= '0;
         idle_prev_q <= 1'b0;
      end
      else if (ce)
      begin
         idle_prev_q <= !busy;
         case (ph_q)
            iexec_pkg::PH_IDLE: if (start_q) ph_q <= iexec_pkg::PH_Q1;
            iexec_pkg::PH_Q1:
            begin
               dec_q <= dec_d;
               ea_q <= ea_d;
               ph_q <= iexec_pkg::PH_Q2;
            end
            iexec_pkg::PH_Q2: ph_q <= iexec_pkg::PH_Q3;
            iexec_pkg::PH_Q3: ph_q <= iexec_pkg::PH_Q4;
            iexec_pkg::PH_Q4: ph_q <= dec_q.slp ? iexec_pkg::PH_SLEEP : iexec_pkg::PH_IDLE;
            iexec_pkg::PH_SLEEP: if (watchdog_s2 || wake_s2) ph_q <= iexec_pkg::PH_IDLE;
            default: ph_q <= iexec_pkg::PH_IDLE;
         endcase
      end
   end

   // ==========================================================================
   // Data path
   // ==========================================================================
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         result_q <= 8'h00;
      end
      else if (ce && ph_q == iexec_pkg::PH_Q3)
      begin
         result_q <= dec_q.set ? iexec_pkg::ALL_ONES : {mem_rdata[0], mem_rdata[7:1]};
      end
   end

   // The memory port is shared; software only reaches it while no instruction runs.
   assign mem_addr = busy ? ea_q : maddr_q;
   assign mem_wdata = busy ? result_q : wdata_q[7:0];
   assign mem_we = (ph_q == iexec_pkg::PH_Q4 && (dec_q.set || (dec_q.rot && dec_q.dst))) ||
                   (do_write && awaddr_q == iexec_pkg::MDATA_OFS && wstrb_q[0]);

   instr_data_ram #(
      .AW(ADDR_W),
      .DW(8)
   ) u_ram (
      .clk(aclk),
      .ce(ce),
      .we(mem_we),
      .addr(mem_addr),
      .wdata(mem_wdata),
      .rdata_q(mem_rdata)
   );

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_q <= iexec_pkg::W_RST;
      end
      else if (ce)
      begin
         if (ph_q == iexec_pkg::PH_Q4 && dec_q.rot && !dec_q.dst)
         begin
            w_q <= result_q;
         end
         else if (do_write && awaddr_q == iexec_pkg::W_OFS)
         begin
            w_q <= 8'(wmerge({24'h0, w_q}, wdata_q, wstrb_q));
         end
      end
   end

   // ==========================================================================
   // Status flags and sleep entry
   // ==========================================================================
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q <= iexec_pkg::STATUS_RST;
      end
      else if (ce)
      begin
         if (ph_q == iexec_pkg::PH_Q4 && dec_q.rot)
         begin
            st_q.n <= result_q[7];
            st_q.z <= (result_q == 8'h00);
         end
         else if (ph_q == iexec_pkg::PH_Q4 && dec_q.slp)
         begin
            st_q.power_down_flag_n <= 1'b0;
            st_q.timeout_flag_n <= 1'b1;
         end
         else if (ph_q == iexec_pkg::PH_SLEEP && watchdog_s2)
         begin
            st_q.timeout_flag_n <= 1'b0;
         end
         else if (do_write && awaddr_q == iexec_pkg::STAT_OFS && wstrb_q[0])
         begin
            st_q.c <= wdata_q[iexec_pkg::ST_C_BIT];
            st_q.z <= wdata_q[iexec_pkg::ST_Z_BIT];
            st_q.n <= wdata_q[iexec_pkg::ST_N_BIT];
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         core_asleep <= 1'b0;
         osc_stop <= 1'b0;
         watchdog_clear <= 1'b0;
         postscaler_clear <= 1'b0;
      end
      else if (ce)
      begin
         watchdog_clear <= (ph_q == iexec_pkg::PH_Q4) && dec_q.slp;
         postscaler_clear <= (ph_q == iexec_pkg::PH_Q4) && dec_q.slp;
         if (ph_q == iexec_pkg::PH_Q4 && dec_q.slp)
         begin
            core_asleep <= 1'b1;
            osc_stop <= 1'b1;
         end
         else if (ph_q == iexec_pkg::PH_SLEEP && (watchdog_s2 || wake_s2))
         begin
            core_asleep <= 1'b0;
            osc_stop <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Software registers
   // ==========================================================================
   assign do_write = aw_hold_q && w_hold_q && !bvalid && !busy;
   assign wr_hit = (awaddr_q == iexec_pkg::CTRL_OFS) || (awaddr_q == iexec_pkg::INSTR_OFS) ||
                   (awaddr_q == iexec_pkg::W_OFS) || (awaddr_q == iexec_pkg::BANK_OFS) ||
                   (awaddr_q == iexec_pkg::STAT_OFS) || (awaddr_q == iexec_pkg::INDEX_OFS) ||
                   (awaddr_q == iexec_pkg::MADDR_OFS) || (awaddr_q == iexec_pkg::MDATA_OFS);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         instr_q <= iexec_pkg::INSTR_RST;
         ext_en_q <= 1'b0;
         start_q <= 1'b0;
         bank_select_reg_q <= '0;
         index_q <= '0;
         maddr_q <= '0;
      end
      else if (ce)
      begin
         // A start while asleep is dropped: the core is halted until a wake.
         start_q <= do_write && awaddr_q == iexec_pkg::CTRL_OFS && wstrb_q[0] &&
                    wdata_q[iexec_pkg::CTRL_GO_BIT] && ph_q == iexec_pkg::PH_IDLE;
         if (do_write && awaddr_q == iexec_pkg::CTRL_OFS && wstrb_q[0])
         begin
            ext_en_q <= wdata_q[iexec_pkg::CTRL_EXT_BIT];
         end
         else if (do_write && awaddr_q == iexec_pkg::INSTR_OFS)
         begin
            instr_q <= 16'(wmerge({16'h0, instr_q}, wdata_q, wstrb_q));
         end
         else if (do_write && awaddr_q == iexec_pkg::BANK_OFS)
         begin
            bank_select_reg_q <= BANK_W'(wmerge(32'(bank_select_reg_q), wdata_q, wstrb_q));
         end
         else if (do_write && awaddr_q == iexec_pkg::INDEX_OFS)
         begin
            index_q <= ADDR_W'(wmerge(32'(index_q), wdata_q, wstrb_q));
         end
         else if (do_write && awaddr_q == iexec_pkg::MADDR_OFS)
         begin
            maddr_q <= ADDR_W'(wmerge(32'(maddr_q), wdata_q, wstrb_q));
         end
      end
   end

   // ==========================================================================
   // AXI4-Lite slave
   // ==========================================================================
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         bvalid <= 1'b0;
         bresp <= iexec_pkg::RESP_OKAY;
      end
      else if (ce)
      begin
         if (awvalid && awready)
         begin
            aw_hold_q <= 1'b1;
            awaddr_q <= awaddr;
            awready <= 1'b0;
         end
         if (wvalid && wready)
         begin
            w_hold_q <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
            wready <= 1'b0;
         end
         if (do_write)
         begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_hit ? iexec_pkg::RESP_OKAY : iexec_pkg::RESP_SLVERR;
         end
         if (bvalid && bready)
         begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // Reads wait one idle cycle so the memory output reflects the software address.
   assign do_read = ar_hold_q && !rvalid && !busy && idle_prev_q;

   always_comb
   begin
      rd_word = 32'h0;
      rd_err = 1'b0;
      if (araddr_q == iexec_pkg::CTRL_OFS)
      begin
         rd_word[iexec_pkg::CTRL_EXT_BIT] = ext_en_q;
      end
      else if (araddr_q == iexec_pkg::INSTR_OFS)
      begin
         rd_word[15:0] = instr_q;
      end
      else if (araddr_q == iexec_pkg::W_OFS)
      begin
         rd_word[7:0] = w_q;
      end
      else if (araddr_q == iexec_pkg::BANK_OFS)
      begin
         rd_word[BANK_W-1:0] = bank_select_reg_q;
      end
      else if (araddr_q == iexec_pkg::STAT_OFS)
      begin
         rd_word[iexec_pkg::ST_C_BIT] = st_q.c;
         rd_word[iexec_pkg::ST_Z_BIT] = st_q.z;
         rd_word[iexec_pkg::ST_N_BIT] = st_q.n;
         rd_word[iexec_pkg::ST_PWR_DOWN_BIT] = st_q.power_down_flag_n;
         rd_word[iexec_pkg::ST_TIMEOUT_BIT] = st_q.timeout_flag_n;
         rd_word[iexec_pkg::ST_SLEEP_BIT] = core_asleep;
         rd_word[iexec_pkg::ST_BUSY_BIT] = busy;
      end
      else if (araddr_q == iexec_pkg::INDEX_OFS)
      begin
         rd_word[ADDR_W-1:0] = index_q;
      end
      else if (araddr_q == iexec_pkg::MADDR_OFS)
      begin
         rd_word[ADDR_W-1:0] = maddr_q;
      end
      else if (araddr_q == iexec_pkg::MDATA_OFS)
      begin
         rd_word[7:0] = mem_rdata;
      end
      else
      begin
         rd_err = 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b1;
         ar_hold_q <= 1'b0;
         araddr_q <= 8'h00;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= iexec_pkg::RESP_OKAY;
      end
      else if (ce)
      begin
         if (arvalid && arready)
         begin
            ar_hold_q <= 1'b1;
            araddr_q <= araddr;
            arready <= 1'b0;
         end
         if (do_read)
         begin
            ar_hold_q <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_err ? iexec_pkg::RESP_SLVERR : iexec_pkg::RESP_OKAY;
         end
         if (rvalid && rready)
         begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   // ==========================================================================
   // Assertions
   // ==========================================================================
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !ce);

   a_indexed_offset: assert property ((ph_q == iexec_pkg::PH_Q1 && !instr_q[8] && ext_en_q &&
      instr_q[7:0] <= iexec_pkg::LIT_OFS_LIMIT) |=> ea_q == index_q + ADDR_W'(instr_q[7:0]))
      else $error("indexed operand address wrong");
   a_rot_result: assert property ((ph_q == iexec_pkg::PH_Q3 && dec_q.rot) |=>
      result_q == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
      else $error("rotate result wrong");
   a_carry_kept: assert property ((ph_q == iexec_pkg::PH_Q4 && !dec_q.set) |=> $stable(st_q.c))
      else $error("carry changed by instruction");
   a_dest_w: assert property ((ph_q == iexec_pkg::PH_Q4 && dec_q.rot && !dec_q.dst) |->
      !mem_we ##1 w_q == $past(result_q))
      else $error("working register destination wrong");
   a_set_ones: assert property ((ph_q == iexec_pkg::PH_Q4 && dec_q.set) |->
      mem_we && mem_wdata == 8'hFF ##1 $stable(st_q))
      else $error("set-all-ones write or flags wrong");
   a_access_bank: assert property ((ph_q == iexec_pkg::PH_Q1 && !instr_q[8] &&
      !(ext_en_q && instr_q[7:0] <= iexec_pkg::LIT_OFS_LIMIT)) |=>
      ea_q[ADDR_W-1:8] == {BANK_W{instr_q[7:0] > iexec_pkg::LIT_OFS_LIMIT}} &&
      ea_q[7:0] == instr_q[7:0])
      else $error("access bank address wrong");
   a_banked_addr: assert property ((ph_q == iexec_pkg::PH_Q1 && instr_q[8]) |=>
      ea_q == {bank_select_reg_q, instr_q[7:0]})
      else $error("banked address wrong");
   a_sleep_entry: assert property ((ph_q == iexec_pkg::PH_Q4 && dec_q.slp) |=>
      !st_q.power_down_flag_n && st_q.timeout_flag_n && core_asleep && osc_stop &&
      ph_q == iexec_pkg::PH_SLEEP)
      else $error("sleep entry state wrong");
   a_watchdog_clear: assert property ((ph_q == iexec_pkg::PH_Q4 && dec_q.slp) |=>
      watchdog_clear && postscaler_clear ##1 !watchdog_clear && !postscaler_clear)
      else $error("watchdog clear pulse wrong");
   a_watchdog_wake: assert property ((ph_q == iexec_pkg::PH_SLEEP && watchdog_s2) |=>
      !st_q.timeout_flag_n && !core_asleep && ph_q == iexec_pkg::PH_IDLE)
      else $error("watchdog wake handling wrong");
   a_four_phase: assert property ((ph_q == iexec_pkg::PH_Q1) |=> ph_q == iexec_pkg::PH_Q2 ##1
      ph_q == iexec_pkg::PH_Q3 ##1 ph_q == iexec_pkg::PH_Q4)
      else $error("instruction cycle not four phases");

   c_rot_to_w: cover property (ph_q == iexec_pkg::PH_Q4 && dec_q.rot && !dec_q.dst);
   c_set_ones: cover property (ph_q == iexec_pkg::PH_Q4 && dec_q.set);
   c_watchdog_wake: cover property (ph_q == iexec_pkg::PH_SLEEP && watchdog_s2);

endmodule

/* File: tb_instr_exec.sv */
/*
 * Self-checking bench for instr_exec: AXI4-Lite master tasks, a flag and memory model.
 * Assumes one 25 MHz clock and the register map of iexec_pkg.
 */
module tb_instr_exec;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 0, aresetn = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, watchdog_timeout = 0, wake_req = 0;
   logic awready, wready, bvalid, arready, rvalid, core_asleep, osc_stop;
   logic watchdog_clear, postscaler_clear;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, v, f, bank;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp, er = iexec_pkg::RESP_OKAY;
   logic [11:0] idx;
   logic c = 0, z = 0, n = 0, pwr_down_n = 1, timeout_n = 1, ext = 0;
   int miscompares = 0, num_checks = 0, pulses = 0;
   always #20 aclk = ~aclk;
   // ===========================================================================
   // Design
   // ===========================================================================
   instr_exec u_instr_exec (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .watchdog_timeout(watchdog_timeout), .wake_req(wake_req),
      .core_asleep(core_asleep), .osc_stop(osc_stop), .watchdog_clear(watchdog_clear),
      .postscaler_clear(postscaler_clear));
   always @(posedge aclk)
   begin
      if (watchdog_clear === 1'b1 && postscaler_clear === 1'b1)
         pulses++;
   end
   // ===========================================================================
   // Tasks
   // ===========================================================================
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task wr(input logic [7:0] ad, input logic [31:0] d);
      logic at, dt;
      at = 0;
      dt = 0;
      @(posedge aclk);
      awaddr <= ad;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(at && dt))
      begin
         @(posedge aclk);
         if (!at && awready) begin at = 1; awvalid <= 0; end
         if (!dt && wready) begin dt = 1; wvalid <= 0; end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      bready <= 0;
      chk("bresp", {30'h0, bresp}, {30'h0, er});
   endtask
   task rdr(input logic [7:0] ad);
      @(posedge aclk);
      araddr <= ad;
      arvalid <= 1;
      rready <= 1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 0;
      rd = rdata;
      chk("rresp", {30'h0, rresp}, {30'h0, er});
   endtask
   task poke(input logic [11:0] ad, input logic [7:0] d);
      wr(iexec_pkg::MADDR_OFS, {20'h0, ad});
      wr(iexec_pkg::MDATA_OFS, {24'h0, d});
   endtask
   task run(input logic [15:0] i);
      wr(iexec_pkg::INSTR_OFS, {16'h0, i});
      wr(iexec_pkg::CTRL_OFS, {30'h0, ext, 1'b1});
      repeat (8) @(posedge aclk);
   endtask
   function logic [31:0] st(input logic s);
      return {25'h0, 1'b0, s, timeout_n, pwr_down_n, n, z, c};
   endfunction
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ===========================================================================
   // Tests
   // ===========================================================================
   initial
   begin
      repeat (4000) @(posedge aclk);
      miscompares++;
      end_sim;
   end
   initial
   begin
      void'($urandom(21));
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      rdr(iexec_pkg::STAT_OFS);
      chk("status", rd, st(0));
      // Carry is set first so that a rotate which touched it would show.
      bank = {4'h0, 4'($urandom)};
      f = 8'($urandom);
      v = 8'($urandom);
      wr(iexec_pkg::BANK_OFS, {24'h0, bank});
      wr(iexec_pkg::STAT_OFS, 32'h1);
      c = 1;
      poke({bank[3:0], f}, v);
      run({iexec_pkg::ROT_OPC, 2'b11, f});
      v = {v[0], v[7:1]};
      n = v[7];
      z = (v == 8'h00);
      rdr(iexec_pkg::MDATA_OFS);
      chk("rotate mem", rd, {24'h0, v});
      rdr(iexec_pkg::STAT_OFS);
      chk("rotate flags", rd, st(0));
      $display("test rotate to file done");
      ext = 1;
      f = 8'h60 | 8'($urandom);
      poke({4'hF, f}, v);
      run({iexec_pkg::ROT_OPC, 2'b00, f});
      rdr(iexec_pkg::W_OFS);
      chk("rotate w", rd, {24'h0, v[0], v[7:1]});
      rdr(iexec_pkg::MDATA_OFS);
      chk("rotate keep", rd, {24'h0, v});
      n = v[0];
      z = (v == 8'h00);
      $display("test rotate to w done");
      idx = 12'($urandom);
      f = 8'($urandom % 96);
      wr(iexec_pkg::INDEX_OFS, {20'h0, idx});
      poke(idx + 12'(f), 8'h5A);
      run({iexec_pkg::SET_OPC, 1'b0, f});
      rdr(iexec_pkg::MDATA_OFS);
      chk("set indexed", rd, 32'hFF);
      rdr(iexec_pkg::STAT_OFS);
      chk("set flags", rd, st(0));
      ext = 0;
      poke({4'h0, f}, 8'h00);
      run({iexec_pkg::SET_OPC, 1'b0, f});
      rdr(iexec_pkg::MDATA_OFS);
      chk("set access", rd, 32'hFF);
      $display("test set done");
      for (int k = 0; k < 2; k++)
      begin
         pulses = 0;
         run(iexec_pkg::SLEEP_OPC);
         pwr_down_n = 0;
         timeout_n = 1;
         rdr(iexec_pkg::STAT_OFS);
         chk("sleep status", rd, st(1));
         chk("watchdog clears", pulses, 1);
         chk("asleep", {30'h0, core_asleep, osc_stop}, 32'h3);
         wake_req <= (k == 0);
         watchdog_timeout <= (k == 1);
         repeat (6) @(posedge aclk);
         wake_req <= 0;
         watchdog_timeout <= 0;
         timeout_n = (k == 0);
         rdr(iexec_pkg::STAT_OFS);
         chk("wake status", rd, st(0));
         chk("awake", {30'h0, core_asleep, osc_stop}, 32'h0);
      end
      $display("test sleep done");
      er = iexec_pkg::RESP_SLVERR;
      wr(8'h20, 32'h1);
      rdr(8'h22);
      chk("unmapped", rd, 32'h0);
      $display("test unmapped done");
      end_sim;
   end
endmodule
